//--- bwi_pkg.sv
// package: constants and carrier types for the bus wait and interrupt controller
// assumes: a single 50 MHz pclk domain
package bwi_pkg;
	localparam int      CLK_MHZ          = 50;
	localparam int      ACK_TIMEOUT_US   = 100;
	localparam int      ACK_TIMEOUT_CYC  = ACK_TIMEOUT_US * CLK_MHZ;
	localparam int      LINE_TIMEOUT_MS  = 50;
	localparam int      LINE_TIMEOUT_CYC = LINE_TIMEOUT_MS * 1000 * CLK_MHZ;
	localparam int      RESET_PULSES     = 8;
	localparam int      IRQ_DELAY_CYC    = 2;
	localparam int      IRQ_ACCEPT_WINDOW_HOLD_CYC    = 2;
	localparam int      STAT_IRQ_ACKNOWLEDGE_STATUS_BIT    = 0;
	localparam int      STAT_OUT_BIT     = 4;
	localparam int      STAT_MEMR_BIT    = 7;
	localparam logic [2:0] PRIO_ACK      = 3'h1;
	localparam logic [2:0] PRIO_MARK     = 3'h6;
	localparam logic [2:0] PRIO_NONE     = 3'h7;
	localparam logic [7:0] STATUS_RST    = 8'h00;
	localparam logic [31:0] ADDR_CTRL    = 32'h0000_0000;
	localparam logic [31:0] ADDR_STAT    = 32'h0000_0004;
	localparam logic [31:0] ADDR_VEC     = 32'h0000_0008;
	localparam logic [31:0] ADDR_STWORD  = 32'h0000_000C;

	typedef enum logic [1:0] {
		RS_HOLD  = 2'b00,
		RS_COUNT = 2'b01,
		RS_RUN   = 2'b10
	} rst_state_t;

	typedef struct packed {
		logic        sync;
		logic        phi2;
		logic        irq_accept_window;
		logic        bus_read_strobe;
		logic        wr_n;
		logic [15:0] addr;
		logic [7:0]  data;
	} cpu_in_t;

	typedef struct packed {
		logic       ack;
		logic [3:0] vec;
		logic [3:0] ext_irq;
	} mod_in_t;
endpackage

//--- bus_wait_irq_control.sv
// bus_wait_irq_control: reset, status latch, wait, acknowledge and interrupt vector glue
// assumes: all processor and module-bus inputs are asynchronous and synchronised here
`timescale 1ns/1ps
`default_nettype none
module bus_wait_irq_control #(
	parameter int ACK_TIMEOUT  = bwi_pkg::ACK_TIMEOUT_CYC,
	parameter int LINE_TIMEOUT = bwi_pkg::LINE_TIMEOUT_CYC
) (
	input  wire logic            pclk,              // clock
	input  wire logic            presetn,           // async reset, low
	input  wire logic            supply_good,       // delayed supply good
	input  wire logic            line_pulse,        // shaped line pulse
	input  wire logic            line_loop_pulse,   // line-locked loop output
	input  wire bwi_pkg::cpu_in_t cpu_i,            // processor pins
	input  wire bwi_pkg::mod_in_t mod_i,            // module bus pins
	input  wire logic            psel,              // apb select
	input  wire logic            penable,           // apb enable
	input  wire logic            pwrite,            // apb write
	input  wire logic [31:0]     paddr,             // apb address
	input  wire logic [31:0]     pwdata,            // apb write data
	output logic      [31:0]     prdata,            // apb read data
	output logic                 pready,            // apb ready
	output logic                 pslverr,           // apb error
	output logic                 sys_reset,         // system reset
	output logic                 cpu_ready,         // processor ready
	output logic                 cpu_irq,           // processor interrupt
	output logic      [7:0]      cpu_data_o,        // vector onto data bus
	output logic                 cpu_data_oe,       // vector drive enable
	output logic                 mem_wr_en,         // memory write allowed
	output logic                 mem_rd_en,         // memory read allowed
	output logic                 irq_identify_request, // identify request
	output logic      [6:0]      ext_ctrl_n         // inverted external address
);
	// two-flop synchronisers
	localparam int NSYNC = 16 + 8 + 4 + 4 + 9;
	logic [NSYNC-1:0] s1_r, s2_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= {cpu_i.addr, cpu_i.data, mod_i.vec, mod_i.ext_irq, mod_i.ack,
				cpu_i.sync, cpu_i.phi2, cpu_i.irq_accept_window, cpu_i.bus_read_strobe, cpu_i.wr_n,
				supply_good, line_pulse, line_loop_pulse};
			s2_r <= s1_r;
		end
	end
	logic [15:0] addr;
	logic [7:0]  data;
	logic [3:0]  vec_bits, ext_irq;
	logic        ack, sync, phi2, irq_accept_window, bus_read_strobe, wr_n, sgood, lpulse, lloop;
	assign {addr, data, vec_bits, ext_irq, ack, sync, phi2, irq_accept_window, bus_read_strobe, wr_n,
		sgood, lpulse, lloop} = s2_r;

	// vector window tracking, used by the flag clears below
	logic [2:0] vec_code;
	logic [2:0] vec_lat_r;
	logic       en_int;
	logic       en_int_d_r;
	logic       vec_done;

	// counter at or past its limit
	function automatic logic reached(input logic [31:0] cnt, input int lim);
		return cnt >= 32'(lim);
	endfunction

	// read window just closed with this code on the bus
	function automatic logic vec_taken(input logic done, input logic [2:0] lat, input logic [2:0] code);
		return done && (lat == code);
	endfunction

	logic lpulse_d_r, lloop_d_r, sync_d_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lpulse_d_r <= 1'b0;
			lloop_d_r  <= 1'b0;
			sync_d_r   <= 1'b0;
		end else begin
			lpulse_d_r <= lpulse;
			lloop_d_r  <= lloop;
			sync_d_r   <= sync;
		end
	end
	logic lpulse_rise, lloop_rise, cycle_start;
	assign lpulse_rise = lpulse & ~lpulse_d_r;
	assign lloop_rise  = lloop & ~lloop_d_r;
	assign cycle_start = sync & ~phi2 & ~sync_d_r;

	// power-up / power-down reset
	bwi_pkg::rst_state_t rs_r;
	logic [3:0]  pulse_cnt_r;
	logic [31:0] wd_cnt_r;
	logic        wd_clear;
	assign wd_clear = ~sgood | reached(wd_cnt_r, LINE_TIMEOUT);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wd_cnt_r <= '0;
		end else if (~sgood || lpulse_rise) begin
			wd_cnt_r <= '0;
		end else if (!reached(wd_cnt_r, LINE_TIMEOUT)) begin
			wd_cnt_r <= wd_cnt_r + 32'h1;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rs_r        <= bwi_pkg::RS_HOLD;
			pulse_cnt_r <= '0;
			sys_reset   <= 1'b1;
		end else if (wd_clear) begin
			rs_r        <= bwi_pkg::RS_HOLD;
			pulse_cnt_r <= '0;
			sys_reset   <= 1'b1;
		end else begin
			case (rs_r)
				bwi_pkg::RS_HOLD: begin
					rs_r <= bwi_pkg::RS_COUNT;
				end
				bwi_pkg::RS_COUNT: begin
					if (lpulse_rise) begin
						pulse_cnt_r <= pulse_cnt_r + 4'h1;
						if (pulse_cnt_r == 4'(bwi_pkg::RESET_PULSES - 1)) begin
							rs_r      <= bwi_pkg::RS_RUN;
							sys_reset <= 1'b0;
						end
					end
				end
				default: begin
					sys_reset <= 1'b0;
				end
			endcase
		end
	end

	// status latch
	logic [7:0] status_r;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_r <= bwi_pkg::STATUS_RST;
		end else if (cycle_start) begin
			status_r <= data;
		end
	end
	logic irq_acknowledge_status, st_out, st_memr, ext_sel, ram_sel;
	assign irq_acknowledge_status    = status_r[bwi_pkg::STAT_IRQ_ACKNOWLEDGE_STATUS_BIT];
	assign st_out  = status_r[bwi_pkg::STAT_OUT_BIT];
	assign st_memr = status_r[bwi_pkg::STAT_MEMR_BIT];
	assign ext_sel = addr[15];
	assign ram_sel = addr[14];

	// reply and timeout
	logic reset_ready_pulse_r, reply_r, ack_irq_r;
	logic [31:0] ack_cnt_r;
	logic delayed_reply;
	assign delayed_reply = ack & (ext_sel | irq_acknowledge_status);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_cnt_r <= '0;
			ack_irq_r <= 1'b0;
		end else if (delayed_reply) begin
			ack_cnt_r <= '0;
		end else if (cycle_start && ext_sel) begin
			ack_cnt_r <= 32'h1;
		end else if (ack_cnt_r != 32'h0) begin
			if (reached(ack_cnt_r, ACK_TIMEOUT)) begin
				ack_cnt_r <= '0;
				ack_irq_r <= 1'b1;
			end else begin
				ack_cnt_r <= ack_cnt_r + 32'h1;
			end
		end else if (vec_taken(vec_done, vec_lat_r, bwi_pkg::PRIO_ACK)) begin
			ack_irq_r <= 1'b0;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reply_r <= 1'b0;
		end else begin
			reply_r <= delayed_reply & ~reset_ready_pulse_r;
		end
	end

	// line tick
	logic arm_r, mark_irq_r, arming;
	assign arming = ~ext_sel & st_out & ~ram_sel;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arm_r      <= 1'b0;
			mark_irq_r <= 1'b0;
		end else begin
			if (cycle_start && ~ext_sel && data[bwi_pkg::STAT_OUT_BIT] && ~ram_sel) begin
				arm_r <= 1'b1;
			end else if (lloop_rise && arm_r) begin
				arm_r <= 1'b0;
			end
			if (lloop_rise && arm_r) begin
				mark_irq_r <= 1'b1;
			end else if (vec_taken(vec_done, vec_lat_r, bwi_pkg::PRIO_MARK)) begin
				mark_irq_r <= 1'b0;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_wr_en <= 1'b0;
			mem_rd_en <= 1'b0;
		end else begin
			mem_wr_en <= ~arming & ~wr_n;
			mem_rd_en <= ~arming & bus_read_strobe & st_memr;
		end
	end

	// interrupt request with delay and hold
	logic any_req, int_req;
	logic [1:0] dly_r, hold_r;
	assign int_req = ack_irq_r | mark_irq_r;
	assign any_req = int_req | (|ext_irq);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dly_r   <= '0;
			hold_r  <= '0;
			cpu_irq <= 1'b0;
		end else begin
			if (any_req && irq_accept_window) begin
				if (dly_r < 2'(bwi_pkg::IRQ_DELAY_CYC)) dly_r <= dly_r + 2'h1;
				else cpu_irq <= 1'b1;
				hold_r <= 2'(bwi_pkg::IRQ_ACCEPT_WINDOW_HOLD_CYC);
			end else if (hold_r != 2'h0) begin
				hold_r <= hold_r - 2'h1;
			end else begin
				dly_r   <= '0;
				cpu_irq <= 1'b0;
			end
		end
	end

	// wait logic
	logic synced_internal_irq, set_ready, rdy_set;
	assign synced_internal_irq = int_req;
	assign set_ready = (reply_r & (ext_sel | irq_acknowledge_status))
		| (synced_internal_irq & irq_acknowledge_status)
		| reached(ack_cnt_r, ACK_TIMEOUT);
	assign rdy_set = (cycle_start & ext_sel) | (cpu_irq & irq_accept_window);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reset_ready_pulse_r    <= 1'b0;
			cpu_ready <= 1'b1;
		end else begin
			reset_ready_pulse_r <= rdy_set;
			if (rdy_set) begin
				cpu_ready <= 1'b0;
			end else if (set_ready) begin
				cpu_ready <= 1'b1;
			end
		end
	end

	// vector encoder; data lines count only while a module replies
	always_comb begin
		vec_code = bwi_pkg::PRIO_NONE;
		if (ack_irq_r) vec_code = bwi_pkg::PRIO_ACK;
		else if (ack && vec_bits[0]) vec_code = 3'h2;
		else if (ack && vec_bits[1]) vec_code = 3'h3;
		else if (ack && vec_bits[2]) vec_code = 3'h4;
		else if (ack && vec_bits[3]) vec_code = 3'h5;
		else if (mark_irq_r) vec_code = bwi_pkg::PRIO_MARK;
	end
	assign en_int = bus_read_strobe & irq_acknowledge_status;
	// flags clear only after the read ends, so the vector holds still
	assign vec_done = en_int_d_r & ~en_int;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			en_int_d_r <= 1'b0;
			vec_lat_r  <= bwi_pkg::PRIO_NONE;
		end else begin
			en_int_d_r <= en_int;
			if (en_int) begin
				vec_lat_r <= vec_code;
			end
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cpu_data_o           <= 8'hFF;
			cpu_data_oe          <= 1'b0;
			irq_identify_request <= 1'b0;
			ext_ctrl_n           <= 7'h7F;
		end else begin
			cpu_data_o           <= ~{5'h00, vec_code};
			cpu_data_oe          <= en_int;
			irq_identify_request <= en_int & ~synced_internal_irq;
			ext_ctrl_n           <= ~addr[14:8];
		end
	end

	// apb: read-only status view
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata  <= '0;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= 1'b0;
			prdata  <= '0;
			if (psel && !penable && !pwrite) begin
				if (paddr == bwi_pkg::ADDR_STAT) begin
					prdata <= {26'h0, arm_r, mark_irq_r, ack_irq_r, cpu_irq, cpu_ready, sys_reset};
				end else if (paddr == bwi_pkg::ADDR_VEC) begin
					prdata <= {29'h0, vec_code};
				end else if (paddr == bwi_pkg::ADDR_STWORD) begin
					prdata <= {24'h0, status_r};
				end else if (paddr != bwi_pkg::ADDR_CTRL) begin
					pslverr <= 1'b1;
				end
			end else if (psel && !penable && paddr != bwi_pkg::ADDR_CTRL) begin
				pslverr <= 1'b1;
			end
		end
	end
	logic unused_wdata;
	assign unused_wdata = ^pwdata;
endmodule
`default_nettype wire

//--- bwi_chk_asserts.sv
// checker: port timing relations of the bus wait and interrupt controller
// assumes: bound into bus_wait_irq_control, one pclk domain
`timescale 1ns/1ps
`default_nettype none
module bwi_chk #(
	parameter int ACK_TIMEOUT = 20
) (
	input wire logic             pclk,        // clock
	input wire logic             presetn,     // async reset, low
	input wire logic             supply_good, // supply good
	input wire logic             line_pulse,  // line pulse
	input wire bwi_pkg::cpu_in_t cpu_i,       // processor pins
	input wire bwi_pkg::mod_in_t mod_i,       // module pins
	input wire logic             sys_reset,   // system reset
	input wire logic             cpu_ready,   // ready
	input wire logic             cpu_irq,     // interrupt
	input wire logic [7:0]       cpu_data_o,  // vector
	input wire logic             cpu_data_oe, // vector enable
	input wire logic             mem_wr_en,   // write allowed
	input wire logic             mem_rd_en,   // read allowed
	input wire logic [6:0]       ext_ctrl_n   // inverted address
);
	logic [3:0]  npls_r;
	logic        lp_r;
	logic [15:0] wcnt_r;

	// line pulse rises since supply good came up
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			npls_r <= 4'h0;
			lp_r <= 1'b0;
		end else begin
			lp_r <= line_pulse;
			if (!supply_good) begin
				npls_r <= 4'h0;
			end else if (line_pulse && !lp_r && npls_r != 4'hF) begin
				npls_r <= npls_r + 4'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wcnt_r <= 16'h0000;
		end else begin
			wcnt_r <= cpu_ready ? 16'h0000 : wcnt_r + 16'h0001;
		end
	end

	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	AST_RST_COUNT: assert property ($fell(sys_reset) |-> npls_r >= 4'h8)
		else $error("reset released early");
	AST_RST_DOWN: assert property ($fell(supply_good) |-> ##[1:6] sys_reset)
		else $error("no reset on supply loss");
	AST_WAIT_EXT: assert property ($rose(cpu_i.sync) && !cpu_i.phi2 && cpu_i.addr[15] && !sys_reset
		|-> ##[1:6] !cpu_ready)
		else $error("no wait on external access");
	AST_WAIT_BOUND: assert property (wcnt_r <= ACK_TIMEOUT + 16)
		else $error("wait outlives timeout");
	AST_ACK_ENDS: assert property (not ((mod_i.ack && !cpu_ready) [*8]))
		else $error("reply does not end wait");
	AST_VEC_FORM: assert property (cpu_data_oe |-> cpu_data_o[7:3] == 5'h1F)
		else $error("vector not complemented");
	AST_VEC_GATE: assert property (!cpu_i.bus_read_strobe [*6] |-> !cpu_data_oe)
		else $error("vector without read strobe");
	AST_IRQ_GATE: assert property (!cpu_i.irq_accept_window [*8] |-> !cpu_irq)
		else $error("irq without enable");
	AST_IRQ_HOLD: assert property ($fell(cpu_i.irq_accept_window) && cpu_irq |=> cpu_irq)
		else $error("irq dropped with enable");
	AST_ARM_QUIET: assert property ($rose(cpu_i.sync) && !cpu_i.phi2 && !cpu_i.addr[15] && !cpu_i.addr[14]
		&& cpu_i.data[4] |-> ##[1:6] (!mem_wr_en && !mem_rd_en))
		else $error("memory strobe on arming");
	AST_EXT_ADDR: assert property ($stable(cpu_i.addr) [*6] |-> ext_ctrl_n == ~cpu_i.addr[14:8])
		else $error("external address not inverted");

	cover property ($fell(sys_reset));
	cover property ($fell(cpu_ready));
	cover property (cpu_data_oe);
endmodule

bind bus_wait_irq_control bwi_chk #(.ACK_TIMEOUT(ACK_TIMEOUT)) u_bwi_chk (
	.pclk(pclk), .presetn(presetn), .supply_good(supply_good), .line_pulse(line_pulse),
	.cpu_i(cpu_i), .mod_i(mod_i), .sys_reset(sys_reset), .cpu_ready(cpu_ready), .cpu_irq(cpu_irq),
	.cpu_data_o(cpu_data_o), .cpu_data_oe(cpu_data_oe), .mem_wr_en(mem_wr_en),
	.mem_rd_en(mem_rd_en), .ext_ctrl_n(ext_ctrl_n));
`default_nettype wire

//--- mod_bus_model.sv
// model: modules on the internal bus answering waits and identify requests
// assumes: changes right after pclk rises, lines as in bwi_pkg::mod_in_t
`timescale 1ns/1ps
`default_nettype none
module mod_bus_model (
	input  wire logic           pclk,      // clock
	input  wire logic           cpu_ready, // low while addressed
	input  wire logic           idreq,     // identify request
	input  wire logic           answer,    // reply at all
	input  wire logic [3:0]     lag,       // reply delay
	input  wire logic [3:0]     irq_src,   // module requests
	input  wire logic [6:0]     ext_ctrl_n, // inverted address lines
	output var bwi_pkg::mod_in_t mod_o     // module pins
);
	logic [3:0] cnt_r;

	initial begin
		mod_o = '0;
		cnt_r = 4'h0;
	end

	always @(posedge pclk) begin
		mod_o.ext_irq <= irq_src;
		// a module answers only when addressed or asked to identify
		if (!(answer && ((!cpu_ready && ext_ctrl_n != 7'h7F) || idreq))) begin
			cnt_r <= 4'h0;
			mod_o.ack <= 1'b0;
			// released data lines do not keep their value
			mod_o.vec <= ~mod_o.vec;
		end else if (cnt_r == lag) begin
			mod_o.ack <= 1'b1;
			mod_o.vec <= idreq ? (irq_src & (~irq_src + 4'h1)) : ~mod_o.vec;
		end else begin
			cnt_r <= cnt_r + 4'h1;
		end
	end
endmodule
`default_nettype wire

//--- bus_wait_irq_control_bench.sv
// bench: drives processor, line and apb inputs of the controller, judges outputs
// assumes: bwi_pkg, the controller, its checker and mod_bus_model compiled first
`timescale 1ns/1ps
`default_nettype none
module bus_wait_irq_control_bench;
	localparam int ACK_TO = 20;
	logic             pclk, presetn, supply_good, line_pulse, line_loop_pulse, answer, er;
	logic             psel, penable, pwrite, pready, pslverr, sys_reset, cpu_ready, cpu_irq;
	logic             cpu_data_oe, mem_wr_en, mem_rd_en, idreq;
	logic [31:0]      paddr, pwdata, prdata, rd;
	logic [7:0]       cpu_data_o;
	logic [6:0]       ext_ctrl_n;
	logic [3:0]       lag, irq_src;
	int               error_cnt, checked, n;
	bwi_pkg::cpu_in_t cpu;
	bwi_pkg::mod_in_t mod;

	bus_wait_irq_control #(.ACK_TIMEOUT(ACK_TO), .LINE_TIMEOUT(200)) u_bus_wait_irq_control (
		.pclk(pclk), .presetn(presetn), .supply_good(supply_good), .line_pulse(line_pulse),
		.line_loop_pulse(line_loop_pulse), .cpu_i(cpu), .mod_i(mod), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .sys_reset(sys_reset), .cpu_ready(cpu_ready), .cpu_irq(cpu_irq),
		.cpu_data_o(cpu_data_o), .cpu_data_oe(cpu_data_oe), .mem_wr_en(mem_wr_en),
		.mem_rd_en(mem_rd_en), .irq_identify_request(idreq), .ext_ctrl_n(ext_ctrl_n));
	mod_bus_model u_mod_bus_model (.pclk(pclk), .cpu_ready(cpu_ready), .idreq(idreq),
		.answer(answer), .lag(lag), .irq_src(irq_src), .ext_ctrl_n(ext_ctrl_n), .mod_o(mod));

	always #10 pclk = ~pclk;

	// free running line pulses, well inside the watchdog span
	always begin
		repeat (40) @(posedge pclk);
		line_pulse <= 1'b1;
		repeat (4) @(posedge pclk);
		line_pulse <= 1'b0;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge pclk);
	endtask

	task automatic apb_rd(input logic [31:0] a);
		@(posedge pclk);
		psel <= 1'b1;
		paddr <= a;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic cyc(input logic [15:0] a, input logic [7:0] st, input logic rds);
		@(posedge pclk);
		cpu.sync <= 1'b0;
		@(posedge pclk);
		cpu.addr <= a;
		cpu.data <= st;
		cpu.bus_read_strobe <= rds;
		cpu.sync <= 1'b1;
	endtask

	task automatic raise_irq();
		cpu.irq_accept_window <= 1'b1;
		for (n = 0; n < 30 && cpu_irq !== 1'b1; n++) @(posedge pclk);
		chk(cpu_irq, 1'b1, "no irq");
		cpu.irq_accept_window <= 1'b0;
		tick(1);
		chk(cpu_irq, 1'b1, "irq not held");
	endtask

	task automatic vec_read(input logic [7:0] exp);
		cyc(16'h0000, 8'h01, 1'b1);
		tick(6);
		for (n = 0; n < 60 && !(cpu_ready === 1'b1 && cpu_data_oe === 1'b1); n++) @(posedge pclk);
		tick(1);
		chk(cpu_data_oe, 1'b1, "no vector");
		chk(cpu_data_o, exp, "vector");
		cpu.bus_read_strobe <= 1'b0;
		cyc(16'h0000, 8'h00, 1'b0);
		tick(8);
	endtask

	task automatic t_power();
		@(negedge line_pulse);
		@(posedge pclk);
		supply_good <= 1'b1;
		repeat (7) @(posedge line_pulse);
		tick(10);
		chk(sys_reset, 1'b1, "reset left early");
		@(posedge line_pulse);
		for (n = 0; n < 20 && sys_reset !== 1'b0; n++) @(posedge pclk);
		chk(sys_reset, 1'b0, "reset stuck");
		apb_rd(bwi_pkg::ADDR_STAT);
		chk(rd[1:0], 2'b10, "status");
		apb_rd(32'h0000_0010);
		chk(er, 1'b1, "unmapped");
	endtask

	task automatic t_ext(input logic [3:0] d, input logic ans);
		answer <= ans;
		lag <= d;
		cyc(16'hA500, 8'h00, 1'b0);
		for (n = 0; n < 10 && cpu_ready !== 1'b0; n++) @(posedge pclk);
		chk(cpu_ready, 1'b0, "no wait");
		chk(ext_ctrl_n, 7'h5A, "ext addr");
		for (n = 0; n < ACK_TO + 30 && cpu_ready !== 1'b1; n++) @(posedge pclk);
		chk(cpu_ready, 1'b1, "wait stuck");
		tick(4);
	endtask

	task automatic t_timeout();
		t_ext(4'h0, 1'b0);
		apb_rd(bwi_pkg::ADDR_STAT);
		chk(rd[3], 1'b1, "no timeout irq");
		raise_irq();
		vec_read(8'hFE);
		apb_rd(bwi_pkg::ADDR_STAT);
		chk(rd[3], 1'b0, "timeout irq kept");
	endtask

	task automatic t_mark();
		cyc(16'h0000, 8'h10, 1'b0);
		tick(6);
		apb_rd(bwi_pkg::ADDR_STAT);
		chk(rd[5], 1'b1, "not armed");
		line_loop_pulse <= 1'b1;
		tick(4);
		line_loop_pulse <= 1'b0;
		tick(4);
		apb_rd(bwi_pkg::ADDR_STAT);
		chk(rd[4], 1'b1, "no tick irq");
		raise_irq();
		vec_read(8'hF9);
	endtask

	task automatic t_ext_irq();
		answer <= 1'b1;
		lag <= 4'h2;
		irq_src <= 4'h4;
		raise_irq();
		vec_read(8'hFB);
		irq_src <= 4'h0;
		tick(10);
	endtask

	task automatic report_and_stop();
		if (error_cnt == 0 && checked > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		error_cnt++;
		report_and_stop();
	end

	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		{supply_good, line_pulse, line_loop_pulse, answer, psel, penable, pwrite} = '0;
		{paddr, pwdata, lag, irq_src} = '0;
		cpu = '0;
		cpu.wr_n = 1'b1;
		error_cnt = 0;
		checked = 0;
		tick(20);
		chk(ext_ctrl_n, 7'h7F, "reset lines");
		presetn <= 1'b1;
		t_power();
		t_ext(4'h1, 1'b1);
		t_ext(4'h9, 1'b1);
		t_timeout();
		t_mark();
		t_ext_irq();
		supply_good <= 1'b0;
		for (n = 0; n < 10 && sys_reset !== 1'b1; n++) @(posedge pclk);
		chk(sys_reset, 1'b1, "no reset on loss");
		report_and_stop();
	end
endmodule
`default_nettype wire
